// File: tof_capture_pkg.sv
// Purpose: shared constants and types for the ultrasonic flight-time capture sequencer
// Assumes: 100 MHz system clock derived from the ultrasonic crystal
// Notes: sample and address widths are fixed here

package tof_capture_pkg;

	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned ADC_W = 12;
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned PULSE_CNT_W = 8;
	localparam int unsigned HALF_PERIOD_W = 8;
	localparam int unsigned TOF_W = 24;

	// leg selection
	typedef enum logic {
		LEG_UP,
		LEG_DOWN
	} leg_t;

	// start request carried from the host
	typedef struct packed {
		leg_t leg;
		logic [PULSE_CNT_W-1:0] pulses;
		logic [HALF_PERIOD_W-1:0] half_period;
		logic [ADDR_W-1:0] base_addr;
		logic [ADDR_W-1:0] sample_count;
	} start_cmd_t;

	// one RAM write toward the shared memory
	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [ADC_W-1:0] data;
	} ram_wr_t;

	localparam logic [ADDR_W-1:0] ADDR_ZERO = 10'h000;
	localparam logic [TOF_W-1:0] TOF_ZERO = 24'h000000;
	localparam logic [PULSE_CNT_W-1:0] PULSE_ZERO = 8'h00;
	localparam logic [HALF_PERIOD_W-1:0] HALF_ONE = 8'h01;

endpackage

// File: tof_pulse_gen.sv
// Purpose: excitation burst generator for one transducer leg
// Assumes: pulses and half_period are held steady while busy
// Notes: half_period of zero is treated as one cycle

`timescale 1ns/1ps

module tof_pulse_gen (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic go_in,
	input wire logic [tof_capture_pkg::PULSE_CNT_W-1:0] pulses_in,
	input wire logic [tof_capture_pkg::HALF_PERIOD_W-1:0] half_period_in,
	output logic drive_out,
	output logic busy_out,
	output logic done_out
);

	logic [tof_capture_pkg::PULSE_CNT_W-1:0] left_q, left_d;
	logic [tof_capture_pkg::HALF_PERIOD_W-1:0] tick_q, tick_d;
	logic drive_q, drive_d;
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic [tof_capture_pkg::HALF_PERIOD_W-1:0] half_eff;

	// a zero half period would wrap the reload to 255 and stretch each half to 256 cycles
	assign half_eff = (half_period_in == '0) ? tof_capture_pkg::HALF_ONE : half_period_in;

	// burst sequencing: each pulse is one high half and one low half
	always_comb begin
		left_d = left_q;
		tick_d = tick_q;
		drive_d = drive_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (!busy_q) begin
			if (go_in && pulses_in != tof_capture_pkg::PULSE_ZERO) begin
				left_d = pulses_in;
				tick_d = half_eff - tof_capture_pkg::HALF_ONE;
				drive_d = 1'b1;
				busy_d = 1'b1;
			end else if (go_in) begin
				done_d = 1'b1;
			end
		end else if (tick_q != '0) begin
			tick_d = tick_q - tof_capture_pkg::HALF_ONE;
		end else begin
			tick_d = half_eff - tof_capture_pkg::HALF_ONE;
			if (drive_q) begin
				drive_d = 1'b0;
			end else if (left_q == 8'h01) begin
				busy_d = 1'b0;
				done_d = 1'b1;
				left_d = tof_capture_pkg::PULSE_ZERO;
			end else begin
				left_d = left_q - 8'h01;
				drive_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			left_q <= '0;
			tick_q <= '0;
			drive_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			left_q <= left_d;
			tick_q <= tick_d;
			drive_q <= drive_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign drive_out = drive_q;
	assign busy_out = busy_q;
	assign done_out = done_q;

endmodule

// File: tof_capture_seq.sv
// Purpose: hardware sequencer for one excite-and-capture leg of a flight-time measurement
// Assumes: adc samples arrive synchronous to clk_in with a one-cycle valid strobe
// Notes: the host starts each leg and keeps the inter-leg gaps itself
//
// Function
// RULE1: logic runs on crystal-derived clock; start initialises and launches pulses.
// RULE2: upstream leg excites first transducer, listens on second transducer.
// RULE3: time from excitation to reception is the upstream flight time.
// RULE4: downstream leg swaps roles: second transmits, first receives.
// RULE5: differential flight time equals downstream minus upstream time.
// RULE6: flight time comes from captured waveform, not zero-crossing timing.
// RULE7: pulses and sampling are sequenced fully in hardware once started.
// RULE8: every captured sample is written into the shared RAM.
// RULE9: after the final sample stored, raise an interrupt to wake the host.
// RULE10: host waits the up-to-down gap before starting downstream leg.
// RULE11: host waits the down-to-up gap before the next upstream leg.
// RULE12: start is accepted only after the current leg's interrupt; else ignored.

`timescale 1ns/1ps

module tof_capture_seq (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic start_in,
	input wire tof_capture_pkg::start_cmd_t cmd_in,
	input wire logic adc_valid_in,
	input wire logic [tof_capture_pkg::ADC_W-1:0] adc_data_in,
	input wire logic echo_detect_in,
	output logic first_transducer_drive_out,
	output logic second_transducer_drive_out,
	output logic first_transducer_listen_out,
	output logic second_transducer_listen_out,
	output logic adc_enable_out,
	output tof_capture_pkg::ram_wr_t ram_wr_out,
	output logic busy_out,
	output logic irq_out,
	output logic [tof_capture_pkg::TOF_W-1:0] upstream_leg_tof_out,
	output logic [tof_capture_pkg::TOF_W-1:0] downstream_leg_tof_out,
	output logic [tof_capture_pkg::TOF_W-1:0] differential_flight_time_out
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXCITE,
		ST_CAPTURE,
		ST_DONE
	} seq_state_t;

	// true while a leg owns the transducers and the converter
	function automatic logic leg_active(input seq_state_t st);
		return st == ST_EXCITE || st == ST_CAPTURE;
	endfunction

	logic rst_meta_q, rst_sync_q;
	seq_state_t state_q, state_d;
	tof_capture_pkg::start_cmd_t cmd_q, cmd_d;
	logic [tof_capture_pkg::ADDR_W-1:0] wr_addr_q, wr_addr_d;
	logic [tof_capture_pkg::ADDR_W-1:0] left_q, left_d;
	logic [tof_capture_pkg::TOF_W-1:0] timer_q, timer_d;
	logic [tof_capture_pkg::TOF_W-1:0] up_tof_q, up_tof_d;
	logic [tof_capture_pkg::TOF_W-1:0] dn_tof_q, dn_tof_d;
	logic echo_seen_q, echo_seen_d;
	tof_capture_pkg::ram_wr_t wr_q, wr_d;
	logic irq_q, irq_d;
	logic gen_go, gen_drive, gen_busy, gen_done;
	logic accept;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// start honoured only from idle or after the completion interrupt
	assign accept = start_in && (state_q == ST_IDLE || state_q == ST_DONE); // RULE12

	// burst launched the cycle a start is accepted
	assign gen_go = accept; // RULE1 RULE7

	tof_pulse_gen u_pulse_gen (
		.clk_in(clk_in),
		.rst_n_in(rst_sync_q),
		.go_in(gen_go),
		.pulses_in(cmd_d.pulses),
		.half_period_in(cmd_d.half_period),
		.drive_out(gen_drive),
		.busy_out(gen_busy),
		.done_out(gen_done)
	);

	// sequencer: excite, then capture a fixed sample count, then interrupt
	always_comb begin
		state_d = state_q;
		cmd_d = cmd_q;
		wr_addr_d = wr_addr_q;
		left_d = left_q;
		timer_d = timer_q;
		up_tof_d = up_tof_q;
		dn_tof_d = dn_tof_q;
		echo_seen_d = echo_seen_q;
		wr_d = '0;
		irq_d = 1'b0;
		case (state_q)
			ST_IDLE, ST_DONE: begin
				if (accept) begin // RULE1
					cmd_d = cmd_in;
					wr_addr_d = cmd_in.base_addr;
					left_d = cmd_in.sample_count;
					timer_d = tof_capture_pkg::TOF_ZERO; // RULE3
					echo_seen_d = 1'b0;
					state_d = ST_EXCITE;
				end
			end
			ST_EXCITE: begin
				timer_d = timer_q + 24'h000001;
				if (gen_done) begin
					state_d = (left_q == '0) ? ST_DONE : ST_CAPTURE;
					irq_d = (left_q == '0);
				end
			end
			ST_CAPTURE: begin
				timer_d = timer_q + 24'h000001;
				// echo marker comes from the waveform processing path, no zero-cross timer
				if (echo_detect_in && !echo_seen_q) begin // RULE6
					echo_seen_d = 1'b1;
					if (cmd_q.leg == tof_capture_pkg::LEG_UP) begin
						up_tof_d = timer_q; // RULE3
					end else begin
						dn_tof_d = timer_q; // RULE4
					end
				end
				if (adc_valid_in) begin
					wr_d.valid = 1'b1; // RULE8
					wr_d.addr = wr_addr_q;
					wr_d.data = adc_data_in;
					wr_addr_d = wr_addr_q + 10'h001;
					left_d = left_q - 10'h001;
					if (left_q == 10'h001) begin
						state_d = ST_DONE;
						irq_d = 1'b1; // RULE9
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			state_q <= ST_IDLE;
			cmd_q <= '0;
			wr_addr_q <= tof_capture_pkg::ADDR_ZERO;
			left_q <= tof_capture_pkg::ADDR_ZERO;
			timer_q <= tof_capture_pkg::TOF_ZERO;
			up_tof_q <= tof_capture_pkg::TOF_ZERO;
			dn_tof_q <= tof_capture_pkg::TOF_ZERO;
			echo_seen_q <= 1'b0;
			wr_q <= '0;
			irq_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cmd_q <= cmd_d;
			wr_addr_q <= wr_addr_d;
			left_q <= left_d;
			timer_q <= timer_d;
			up_tof_q <= up_tof_d;
			dn_tof_q <= dn_tof_d;
			echo_seen_q <= echo_seen_d;
			wr_q <= wr_d;
			irq_q <= irq_d;
		end
	end

	// transducer routing by leg; excite one, listen on the other
	always_comb begin
		first_transducer_drive_out = 1'b0;
		second_transducer_drive_out = 1'b0;
		first_transducer_listen_out = 1'b0;
		second_transducer_listen_out = 1'b0;
		if (leg_active(state_q)) begin
			if (cmd_q.leg == tof_capture_pkg::LEG_UP) begin
				first_transducer_drive_out = gen_drive; // RULE2
				second_transducer_listen_out = 1'b1; // RULE2
			end else begin
				second_transducer_drive_out = gen_drive; // RULE4
				first_transducer_listen_out = 1'b1; // RULE4
			end
		end
	end

	assign adc_enable_out = leg_active(state_q); // RULE7
	assign ram_wr_out = wr_q;
	assign busy_out = leg_active(state_q) || gen_busy;
	assign irq_out = irq_q;
	assign upstream_leg_tof_out = up_tof_q;
	assign downstream_leg_tof_out = dn_tof_q;
	// difference wraps modulo the field width when upstream exceeds downstream
	assign differential_flight_time_out = dn_tof_q - up_tof_q; // RULE5

endmodule

// File: tof_pipe_model.sv
// Purpose: transducer pair on the pipe, seen from the sequencer
// Assumes: the echo arrives a fixed delay after the converter is enabled
// Notes: a sample every second cycle; the data line flips when idle
`timescale 1ns/1ps
module tof_pipe_model #(parameter int UP_DLY = 20, parameter int DN_DLY = 27) (
	input wire logic clk_in,
	input wire logic adc_enable_in,
	input wire logic first_listen_in,
	output logic adc_valid_out,
	output logic [tof_capture_pkg::ADC_W-1:0] adc_data_out,
	output logic echo_out
);
	int cnt_q = 0;
	// time since the receiver opened; the flight time differs per direction
	always_ff @(posedge clk_in) begin
		cnt_q <= adc_enable_in ? cnt_q + 1 : 0;
	end
	// half-rate samples, so capture also sees gaps between strobes
	assign adc_valid_out = cnt_q[0];
	assign adc_data_out = adc_valid_out ? cnt_q[11:0] : ~cnt_q[11:0];
	assign echo_out = cnt_q == (first_listen_in ? DN_DLY : UP_DLY);
endmodule

// File: tof_capture_seq_properties.sv
// Purpose: port properties of the capture sequencer
// Assumes: one clock, active-low reset
// Notes: bound to the sequencer module by the bind statement below
`timescale 1ns/1ps
module tof_capture_seq_checker (
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic start_in,
	input wire logic adc_valid_in,
	input wire logic [tof_capture_pkg::ADC_W-1:0] adc_data_in,
	input wire logic first_transducer_drive_out,
	input wire logic second_transducer_drive_out,
	input wire logic first_transducer_listen_out,
	input wire logic second_transducer_listen_out,
	input wire logic adc_enable_out,
	input wire tof_capture_pkg::ram_wr_t ram_wr_out,
	input wire logic busy_out,
	input wire logic irq_out,
	input wire logic [tof_capture_pkg::TOF_W-1:0] upstream_leg_tof_out,
	input wire logic [tof_capture_pkg::TOF_W-1:0] downstream_leg_tof_out,
	input wire logic [tof_capture_pkg::TOF_W-1:0] differential_flight_time_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!arst_n_in);
	// a start seen while idle opens a leg one cycle on
	sequence accept_s;
		start_in && !busy_out;
	endsequence
	sequence open_s;
		busy_out && adc_enable_out;
	endsequence
	a_start_opens_leg: assert property (accept_s |=> open_s) else $error("start not taken");
	// a stray start may coincide with the last sample, so the leg may end with its interrupt
	a_busy_start_ignored: assert property (busy_out && start_in |=> busy_out || irq_out)
		else $error("leg cut");
	a_one_side_drives: assert property (!(first_transducer_drive_out && second_transducer_drive_out))
		else $error("both drive");
	a_up_rx_second: assert property (first_transducer_drive_out |-> second_transducer_listen_out)
		else $error("up rx");
	a_down_rx_first: assert property (second_transducer_drive_out |-> first_transducer_listen_out)
		else $error("down rx");
	a_sample_stored: assert property (ram_wr_out.valid |->
		$past(adc_valid_in) && ram_wr_out.data == $past(adc_data_in)) else $error("bad write");
	a_leg_end_irq: assert property ($fell(busy_out) |-> irq_out) else $error("no irq");
	a_irq_one_pulse: assert property (irq_out |=> !irq_out) else $error("irq long");
	a_diff_is_sub: assert property (
		differential_flight_time_out == downstream_leg_tof_out - upstream_leg_tof_out) else $error("bad diff");
	a_tof_held_idle: assert property (!busy_out && !start_in |=> $stable(upstream_leg_tof_out))
		else $error("tof moved");
endmodule
bind tof_capture_seq tof_capture_seq_checker u_chk (.clk_in, .arst_n_in, .start_in, .adc_valid_in, .adc_data_in,
	.first_transducer_drive_out, .second_transducer_drive_out, .first_transducer_listen_out,
	.second_transducer_listen_out, .adc_enable_out, .ram_wr_out, .busy_out, .irq_out, .upstream_leg_tof_out,
	.downstream_leg_tof_out, .differential_flight_time_out);

// File: tb.sv
// Purpose: self-checking bench for the capture sequencer
// Assumes: inputs change on the falling edge
// Notes: flight times come from the pipe model delays
`timescale 1ns/1ps
module tb;
	logic clk_in = 0, arst_n_in = 0, start_in = 0, adc_valid_in, echo_detect_in;
	logic first_transducer_drive_out, second_transducer_drive_out, first_transducer_listen_out;
	logic second_transducer_listen_out, adc_enable_out, busy_out, irq_out;
	logic [11:0] adc_data_in;
	logic [23:0] upstream_leg_tof_out, downstream_leg_tof_out, differential_flight_time_out;
	logic [9:0] exp_addr;
	tof_capture_pkg::start_cmd_t cmd_in = '0;
	tof_capture_pkg::ram_wr_t ram_wr_out;
	int failures = 0, n_tests = 0, cyc = 0, n_wr;
	always #5 clk_in = ~clk_in;
	tof_capture_seq uut (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.start_in(start_in),
		.cmd_in(cmd_in),
		.adc_valid_in(adc_valid_in),
		.adc_data_in(adc_data_in),
		.echo_detect_in(echo_detect_in),
		.first_transducer_drive_out(first_transducer_drive_out),
		.second_transducer_drive_out(second_transducer_drive_out),
		.first_transducer_listen_out(first_transducer_listen_out),
		.second_transducer_listen_out(second_transducer_listen_out),
		.adc_enable_out(adc_enable_out),
		.ram_wr_out(ram_wr_out),
		.busy_out(busy_out),
		.irq_out(irq_out),
		.upstream_leg_tof_out(upstream_leg_tof_out),
		.downstream_leg_tof_out(downstream_leg_tof_out),
		.differential_flight_time_out(differential_flight_time_out)
	);
	tof_pipe_model pipe (.clk_in(clk_in), .adc_enable_in(adc_enable_out),
		.first_listen_in(first_transducer_listen_out), .adc_valid_out(adc_valid_in),
		.adc_data_out(adc_data_in), .echo_out(echo_detect_in));
	task automatic end_sim;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one leg driven and judged; poke sends stray starts in excite and in capture that must change nothing
	task automatic leg(input logic dn, input logic [9:0] base, input logic [9:0] n, input logic [7:0] p,
		input logic [7:0] h, input logic poke);
		logic tx, tx_prev;
		int n_pulse;
		logic [11:0] exp_data;
		logic [3:0] st;
		cmd_in = '{dn ? tof_capture_pkg::LEG_DOWN : tof_capture_pkg::LEG_UP, p, h, base, n};
		start_in = 1;
		n_wr = 0;
		n_pulse = 0;
		tx_prev = 1'b0;
		exp_addr = base;
		// the model counts from the start; first stored sample follows burst plus done flag
		exp_data = 12'(2 * p * ((h == 8'h00) ? 1 : h) + 1);
		// first pass always runs, since a back-to-back start still sees the last interrupt
		for (int k = 0; (k == 0 || irq_out !== 1'b1) && k < 400; k++) begin
			@(negedge clk_in);
			start_in = poke && (k == 3 || k == 12);
			if (start_in) cmd_in.base_addr = 10'h155;
			tx = dn ? second_transducer_drive_out : first_transducer_drive_out;
			if (tx === 1'b1 && tx_prev !== 1'b1) n_pulse++;
			tx_prev = tx;
			if (first_transducer_drive_out === 1'b1 || second_transducer_drive_out === 1'b1) begin
				chk(second_transducer_drive_out, dn);
			end
			st = {busy_out, adc_enable_out, first_transducer_listen_out, second_transducer_listen_out};
			chk(st, (irq_out === 1'b1) ? 24'h000000 : (dn ? 24'h00000E : 24'h00000D));
			if (ram_wr_out.valid === 1'b1) begin
				chk(ram_wr_out.addr, exp_addr);
				chk(ram_wr_out.data, exp_data);
				exp_addr++;
				exp_data = exp_data + 12'h002;
				n_wr++;
			end
		end
		chk(irq_out, 1'b1);
		chk(n_wr, n);
		chk(n_pulse, p);
	endtask
	// upstream leg whose addresses wrap past the top of the 10-bit space
	task automatic test_upstream;
		leg(1'b0, 10'h3F8, 10'h010, 8'h02, 8'h02, 1'b0);
		chk(upstream_leg_tof_out, 24'h000014);
		$display("upstream leg done at %0t", $time);
	endtask
	// downstream leg with stray starts; flight times follow the pipe model delays
	task automatic test_downstream;
		leg(1'b1, 10'h020, 10'h010, 8'h02, 8'h02, 1'b1);
		chk(downstream_leg_tof_out, 24'h00001B);
		chk(upstream_leg_tof_out, 24'h000014);
		chk(differential_flight_time_out, 24'h000007);
		$display("downstream leg done at %0t", $time);
	endtask
	// reset in mid-leg clears the checked outputs and the upstream time; the outputs stay clear three cycles after the release, with no start
	task automatic test_reset_mid_leg;
		logic [7:0] outs;
		cmd_in = '{tof_capture_pkg::LEG_UP, 8'h02, 8'h02, 10'h000, 10'h010};
		start_in = 1;
		@(negedge clk_in);
		start_in = 0;
		repeat (14) @(negedge clk_in);
		arst_n_in = 0;
		repeat (2) @(negedge clk_in);
		outs = {busy_out, adc_enable_out, irq_out, ram_wr_out.valid, first_transducer_drive_out,
			second_transducer_drive_out, first_transducer_listen_out, second_transducer_listen_out};
		chk(outs, 24'h000000);
		chk(upstream_leg_tof_out, 24'h000000);
		arst_n_in = 1;
		repeat (3) @(negedge clk_in);
		outs = {busy_out, adc_enable_out, irq_out, ram_wr_out.valid, first_transducer_drive_out,
			second_transducer_drive_out, first_transducer_listen_out, second_transducer_listen_out};
		chk(outs, 24'h000000);
		$display("mid-leg reset done at %0t", $time);
	endtask
	// single pulse with a zero half period and no samples: interrupt right after the burst
	task automatic test_short_burst;
		leg(1'b0, 10'h000, 10'h000, 8'h01, 8'h00, 1'b0);
		$display("short burst done at %0t", $time);
	endtask
	// no burst, two samples, started in the same cycle as the previous interrupt
	task automatic test_no_burst;
		leg(1'b0, 10'h100, 10'h002, 8'h00, 8'h02, 1'b0);
		$display("no-burst leg done at %0t", $time);
	endtask
	// cut a hang short
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			end_sim();
		end
	end
	initial begin
		repeat (2) @(negedge clk_in);
		arst_n_in = 1;
		repeat (3) @(negedge clk_in);
		test_upstream();
		repeat (20) @(negedge clk_in);
		test_downstream();
		repeat (30) @(negedge clk_in);
		test_reset_mid_leg();
		test_short_burst();
		test_no_burst();
		end_sim();
	end
endmodule
